// ### src/mmd_manager.sv
// Purpose: station manager running indirect extended register accesses
// Assumes: software port: addr, wdata, write and read strobes, data next cycle
// Notes:   one command at a time; busy while a sequence runs
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module mmd_manager
   import mmd_regs_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [15:0] RDATA_O,
   mgmt_if.manager          MG
);
   import mmd_regs_pkg::*;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001, S_DEV = 6'b000010, S_REG = 6'b000100,
      S_OPD  = 6'b001000, S_ACC = 6'b010000, S_CAP = 6'b100000
   } state_t;

   state_t      st_q;
   logic [4:0]  dev_q;
   logic [15:0] reg_q;
   logic [15:0] data_q;
   logic [15:0] rd_res_q;
   logic        is_wr_q;
   logic        is_dir_q;
   logic        done_q;
   logic [15:0] sw_rd_q;
   logic        m_wr;
   logic        m_rd;
   logic [4:0]  m_addr;
   logic [15:0] m_wdata;

   wire         busy  = (st_q != S_IDLE);
   wire         go    = WR_I && ADDR_I == M_CMD_OFS && !busy;

   // sequencer walking the indirect steps
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_q     <= S_IDLE;
         is_wr_q  <= 1'b0;
         is_dir_q <= 1'b0;
         done_q   <= 1'b0;
         rd_res_q <= 16'h0000;
      end else begin
         case (st_q)
            // command bit 1 skips the pointer steps for a direct basic control access
            S_IDLE: if (go) begin
               st_q     <= WDATA_I[1] ? S_ACC : S_DEV;
               is_wr_q  <= WDATA_I[0];
               is_dir_q <= WDATA_I[1];
               done_q   <= 1'b0;
            end
            S_DEV:   st_q <= S_REG;
            S_REG:   st_q <= S_OPD;
            S_OPD:   st_q <= S_ACC;
            S_ACC:   st_q <= S_CAP;
            S_CAP: begin
               st_q   <= S_IDLE;
               done_q <= 1'b1;
               if (!is_wr_q)
                  rd_res_q <= MG.rdata;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // bus drive per step: dev with op 00, reg number, data op, access
   always_comb begin
      m_wr    = 1'b0;
      m_rd    = 1'b0;
      m_addr  = ACC_CTRL_REG;
      m_wdata = 16'h0000;
      case (st_q)
         S_DEV: begin
            m_wr    = 1'b1;
            m_wdata = {OP_REGISTER, 9'h000, dev_q};
         end
         S_REG: begin
            m_wr    = 1'b1;
            m_addr  = ACC_DATA_REG;
            m_wdata = reg_q;
         end
         S_OPD: begin
            m_wr    = 1'b1;
            m_wdata = {OP_DATA, 9'h000, dev_q};
         end
         S_ACC: begin
            m_wr    = is_wr_q;
            m_rd    = !is_wr_q;
            m_addr  = is_dir_q ? BASIC_CTRL_REG : ACC_DATA_REG;
            m_wdata = data_q;
         end
         default: m_wr = 1'b0;
      endcase
   end

   // software registers; are software's duty, passed through
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         dev_q   <= 5'h00;
         reg_q   <= 16'h0000;
         data_q  <= 16'h0000;
         sw_rd_q <= 16'h0000;
      end else begin
         if (WR_I && ADDR_I == M_DEV_OFS)
            dev_q <= WDATA_I[4:0];
         if (WR_I && ADDR_I == M_REG_OFS)
            reg_q <= WDATA_I;
         if (WR_I && ADDR_I == M_DATA_OFS)
            data_q <= WDATA_I;
         if (RD_I) begin
            case (ADDR_I)
               M_DEV_OFS:   sw_rd_q <= {11'h000, dev_q};
               M_REG_OFS:   sw_rd_q <= reg_q;
               M_DATA_OFS:  sw_rd_q <= data_q;
               M_STAT_OFS:  sw_rd_q <= {14'h0000, done_q, busy};
               M_RDATA_OFS: sw_rd_q <= rd_res_q;
               default:     sw_rd_q <= 16'h0000;
            endcase
         end
      end
   end

   assign MG.wr    = m_wr;
   assign MG.rd    = m_rd;
   assign MG.addr  = m_addr;
   assign MG.wdata = m_wdata;
   assign RDATA_O  = sw_rd_q;
endmodule

// ### src/mmd_regs_pkg.sv
// Purpose: shared constants for the extended register slice and its manager
// Assumes: 16-bit management data, indirect access through control/data regs
// Notes:   offsets, codes and reset values are named once here
package mmd_regs_pkg;
   // direct register numbers
   localparam logic [4:0]  BASIC_CTRL_REG    = 5'h00;
   localparam logic [4:0]  ACC_CTRL_REG      = 5'h0D;
   localparam logic [4:0]  ACC_DATA_REG      = 5'h0E;
   // access control fields
   localparam int          OP_HI             = 15;
   localparam int          OP_LO             = 14;
   localparam logic [1:0]  OP_REGISTER       = 2'h0;
   localparam logic [1:0]  OP_DATA           = 2'h1;
   localparam logic [1:0]  OP_DATA_INC_RW    = 2'h2;
   localparam logic [1:0]  OP_DATA_INC_WR    = 2'h3;
   // device numbers and extended offsets
   localparam logic [4:0]  DEV_AN            = 5'h00;
   localparam logic [4:0]  DEV_PMA           = 5'h01;
   localparam logic [4:0]  DEV_VENDOR        = 5'h02;
   localparam logic [15:0] FLP_LO_OFS        = 16'h0003;
   localparam logic [15:0] FLP_HI_OFS        = 16'h0004;
   localparam logic [15:0] LINKUP_OFS        = 16'h005A;
   localparam logic [15:0] LED_CTRL_OFS      = 16'h0000;
   // reset values and codes
   localparam logic [15:0] FLP_LO_8MS        = 16'h4000;
   localparam logic [15:0] FLP_LO_16MS       = 16'h1A80;
   localparam logic [15:0] FLP_HI_8MS        = 16'h0003;
   localparam logic [15:0] FLP_HI_16MS       = 16'h0006;
   localparam logic [4:0]  LINKUP_RSVD_RST   = 5'h10;
   localparam logic [2:0]  LINKUP_DEFAULT    = 3'h4;
   localparam logic [2:0]  LINKUP_SHORT      = 3'h3;
   localparam logic [15:0] BASIC_CTRL_RST    = 16'h1140;
   localparam logic [15:0] BASIC_FORCED_100  = 16'h2100;
   localparam int          LED_OVR_BIT       = 4;
   localparam int          LED_STAT_BIT      = 3;
   // manager register map (software side)
   localparam logic [3:0]  M_DEV_OFS         = 4'h0;
   localparam logic [3:0]  M_REG_OFS         = 4'h1;
   localparam logic [3:0]  M_DATA_OFS        = 4'h2;
   localparam logic [3:0]  M_CMD_OFS         = 4'h3;
   localparam logic [3:0]  M_STAT_OFS        = 4'h4;
   localparam logic [3:0]  M_RDATA_OFS       = 4'h5;
   localparam logic [3:0]  M_DIRECT_OFS      = 4'h6;
endpackage

// ### src/mgmt_if.sv
// Purpose: register access path between manager and transceiver slice
// Assumes: one cycle write, read data valid the cycle after read strobe
// Notes:   no clocking block
`timescale 1ns/10ps
interface mgmt_if;
   logic        wr;
   logic        rd;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport device  (input wr, input rd, input addr, input wdata, output rdata);
   modport manager (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ### src/phy_mmd_vendor_control_regs.sv
// Purpose: extended register slice: burst interval, link-up time, led_config_select
// Assumes: manager obeys indirect access sequence; strap steady at reset
// Notes:   reads return data one cycle after the read strobe
// Contract
// - high burst register resets 0003, 0006 selects 16ms
// - manager keeps both burst halves matched; mmd_manager passes them through unchecked
// - manager writes only defined high codes
// - low burst register resets 4000, 1A80 selects 16ms
// - link-up time field powers up 100
// - code 011 selects shortened gigabit link-up
// - manager may use short code with anyone
// - manager writes only link-up codes 100, 011
// - link-up field reachable only when basic control 2100
// - led override bit write-only, reads zero
// - override write replaces led_config_select status
// - status 1 single led, 0 tri-colour dual
// - status loads strap at reset, override afterwards
// - indirect access through control and data registers
`timescale 1ns/10ps
module phy_mmd_vendor_control_regs
   import mmd_regs_pkg::*;
(
   input  wire logic   CLK_I,
   input  wire logic   RST_I,
   mgmt_if.device      MG,
   input  wire logic   LED_STRAP_I,
   output logic        LED_SINGLE_O,
   output logic        FLP_16MS_O,
   output logic        LINKUP_SHORT_O
);
   import mmd_regs_pkg::*;

   logic [15:0] basic_q;
   logic [15:0] acc_ctrl_q;
   logic [15:0] acc_reg_q;
   logic [15:0] flp_lo_q;
   logic [15:0] flp_hi_q;
   logic [2:0]  linkup_q;
   logic        led_q;
   logic        strap_load_q;
   logic [15:0] rdata_q;

   // decode of the indirect data access
   wire  [1:0]  op       = acc_ctrl_q[OP_HI:OP_LO];
   wire  [4:0]  dev      = acc_ctrl_q[4:0];
   wire         data_op  = (op != OP_REGISTER);
   wire         wr_ctl   = MG.wr && (MG.addr == ACC_CTRL_REG);
   wire         wr_acc   = MG.wr && (MG.addr == ACC_DATA_REG);
   wire         rd_acc   = MG.rd && (MG.addr == ACC_DATA_REG);
   wire         wr_data  = wr_acc && data_op;
   wire         hit_lo   = (dev == DEV_AN) && (acc_reg_q == FLP_LO_OFS);
   wire         hit_hi   = (dev == DEV_AN) && (acc_reg_q == FLP_HI_OFS);
   wire         hit_lu   = (dev == DEV_PMA) && (acc_reg_q == LINKUP_OFS);
   wire         hit_led  = (dev == DEV_VENDOR) && (acc_reg_q == LED_CTRL_OFS);
   wire         lu_open  = (basic_q == BASIC_FORCED_100);
   wire         inc_rd   = (op == OP_DATA_INC_RW);
   wire         inc_wr   = (op == OP_DATA_INC_RW) || (op == OP_DATA_INC_WR);

   // extended read value, reserved bits at reset levels
   logic [15:0] ext_rd;
   always_comb begin
      ext_rd = 16'h0000;
      if (hit_lo) begin
         ext_rd = flp_lo_q;
      end else if (hit_hi) begin
         ext_rd = flp_hi_q;
      end else if (hit_lu && lu_open) begin
         ext_rd = {7'h00, LINKUP_RSVD_RST, linkup_q, 1'b0};
      end else if (hit_led) begin
         ext_rd = {11'h000, 1'b0, led_q, 3'h0};
      end
   end

   // direct registers and the indirect pointer
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         basic_q    <= BASIC_CTRL_RST;
         acc_ctrl_q <= 16'h0000;
         acc_reg_q  <= 16'h0000;
      end else begin
         if (MG.wr && MG.addr == BASIC_CTRL_REG)
            basic_q <= MG.wdata;
         if (wr_ctl)
            acc_ctrl_q <= MG.wdata;
         if (wr_acc && !data_op)
            acc_reg_q <= MG.wdata;
         else if ((wr_data && inc_wr) || (rd_acc && data_op && inc_rd))
            acc_reg_q <= acc_reg_q + 16'h0001;
      end
   end

   // extended storage
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         flp_lo_q <= FLP_LO_8MS;
         flp_hi_q <= FLP_HI_8MS;
         linkup_q <= LINKUP_DEFAULT;
      end else if (wr_data) begin
         if (hit_lo)
            flp_lo_q <= MG.wdata;
         if (hit_hi)
            flp_hi_q <= MG.wdata;
         if (hit_lu && lu_open)
            linkup_q <= MG.wdata[3:1];
      end
   end

   // led_config_select: strap caught on the first edge after release
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         strap_load_q <= 1'b1;
         led_q        <= 1'b0;
      end else begin
         strap_load_q <= 1'b0;
         if (strap_load_q)
            led_q <= LED_STRAP_I;
         else if (wr_data && hit_led)
            led_q <= MG.wdata[LED_OVR_BIT];
      end
   end

   // read data one cycle after strobe
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rdata_q <= 16'h0000;
      end else if (MG.rd) begin
         case (MG.addr)
            BASIC_CTRL_REG: rdata_q <= basic_q;
            ACC_CTRL_REG:   rdata_q <= acc_ctrl_q;
            ACC_DATA_REG:   rdata_q <= data_op ? ext_rd : acc_reg_q;
            default:        rdata_q <= 16'h0000;
         endcase
      end
   end

   assign MG.rdata       = rdata_q;
   assign LED_SINGLE_O   = led_q;
   assign FLP_16MS_O     = (flp_hi_q == FLP_HI_16MS) && (flp_lo_q == FLP_LO_16MS);
   assign LINKUP_SHORT_O = (linkup_q == LINKUP_SHORT);
endmodule

// ### verif/mmd_regs_checker.sv
// Purpose: assertions on the management path between manager and slice
// Assumes: manager uses data op without post increment
// Notes:   shadow copies of the registers follow the bus writes
`timescale 1ns/10ps
module mmd_regs_checker
   import mmd_regs_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [4:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        LED_STRAP_I,
   input  wire logic        LED_SINGLE_O,
   input  wire logic        FLP_16MS_O,
   input  wire logic        LINKUP_SHORT_O
);
   logic [1:0]  op_q;
   logic [4:0]  dev_q;
   logic [15:0] reg_q, hi_q, lo_q, basic_q;
   logic [2:0]  lk_q;
   // decode of the indirect pointer
   wire         dacc    = (addr == ACC_DATA_REG) && (op_q != OP_REGISTER);
   wire         hit_hi  = (dev_q == DEV_AN) && (reg_q == FLP_HI_OFS);
   wire         hit_lo  = (dev_q == DEV_AN) && (reg_q == FLP_LO_OFS);
   wire         hit_lk  = (dev_q == DEV_PMA) && (reg_q == LINKUP_OFS);
   wire         hit_led = (dev_q == DEV_VENDOR) && (reg_q == LED_CTRL_OFS);
   wire         lk_open = (basic_q == BASIC_FORCED_100);
   wire         ovr_bit = wdata[LED_OVR_BIT];
   wire [15:0]  flp_exp = hit_hi ? hi_q : lo_q;
   wire [15:0]  lk_exp  = lk_open ? {7'h00, LINKUP_RSVD_RST, lk_q, 1'b0} : 16'h0000;
   // shadow registers updated from bus writes
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         hi_q    <= FLP_HI_8MS;
         lo_q    <= FLP_LO_8MS;
         basic_q <= BASIC_CTRL_RST;
         lk_q    <= LINKUP_DEFAULT;
      end else if (wr) begin
         if (addr == ACC_CTRL_REG) op_q <= wdata[OP_HI:OP_LO];
         if (addr == ACC_CTRL_REG) dev_q <= wdata[4:0];
         if (addr == ACC_DATA_REG && !dacc) reg_q <= wdata;
         if (addr == BASIC_CTRL_REG) basic_q <= wdata;
         if (dacc && hit_hi) hi_q <= wdata;
         if (dacc && hit_lo) lo_q <= wdata;
         if (dacc && hit_lk && lk_open) lk_q <= wdata[3:1];
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // a data read through the access data register
   sequence data_rd_s(hit);
      rd && dacc && hit;
   endsequence
   strobe_excl_a: assert property (!(wr && rd)) else $error("strobes overlap");
   flp_out_a: assert property (FLP_16MS_O == (hi_q == FLP_HI_16MS && lo_q == FLP_LO_16MS))
      else $error("burst interval output wrong");
   flp_rd_a: assert property (data_rd_s(hit_hi || hit_lo) |=> rdata == $past(flp_exp))
      else $error("burst interval read wrong");
   lk_rd_a: assert property (data_rd_s(hit_lk) |=> rdata == $past(lk_exp))
      else $error("link-up read wrong");
   lk_out_a: assert property (LINKUP_SHORT_O == (lk_q == LINKUP_SHORT)) else $error("short link-up");
   led_rd_a: assert property (data_rd_s(hit_led) |=> rdata == {12'h000, $past(LED_SINGLE_O), 3'h0})
      else $error("led register read wrong");
   led_ovr_a: assert property (wr && dacc && hit_led |=> LED_SINGLE_O == $past(ovr_bit))
      else $error("led override lost");
   strap_load_a: assert property ($fell(RST_I) |-> ##2 LED_SINGLE_O == LED_STRAP_I)
      else $error("strap not loaded");
endmodule

// ### verif/tb.sv
// Purpose: drives the manager software port, both ends joined by the bus
// Assumes: manager op 01, basic control at its reset value until set to 2100 late in the test
// Notes:   link-up field is seen refusing access first, then read and written once opened
`timescale 1ns/10ps
module tb;
   import mmd_regs_pkg::*;
   logic        CLK_I, RST_I, WR_I, RD_I, LED_STRAP_I;
   logic [3:0]  ADDR_I;
   logic [15:0] WDATA_I, RDATA_O, rv;
   logic        LED_SINGLE_O, FLP_16MS_O, LINKUP_SHORT_O;
   int          error_cnt, checks, cyc;
   mgmt_if mg ();
   phy_mmd_vendor_control_regs i_phy_mmd_vendor_control_regs (.CLK_I(CLK_I), .RST_I(RST_I), .MG(mg),
      .LED_STRAP_I(LED_STRAP_I), .LED_SINGLE_O(LED_SINGLE_O), .FLP_16MS_O(FLP_16MS_O),
      .LINKUP_SHORT_O(LINKUP_SHORT_O));
   mmd_manager i_mmd_manager (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MG(mg));
   mmd_regs_checker i_mmd_regs_checker (.CLK_I(CLK_I), .RST_I(RST_I), .wr(mg.wr), .rd(mg.rd),
      .addr(mg.addr), .wdata(mg.wdata), .rdata(mg.rdata), .LED_STRAP_I(LED_STRAP_I),
      .LED_SINGLE_O(LED_SINGLE_O), .FLP_16MS_O(FLP_16MS_O), .LINKUP_SHORT_O(LINKUP_SHORT_O));
   // clock at 125 mhz
   initial begin
      CLK_I = 1'b0;
      forever #4 CLK_I = ~CLK_I;
   end
   task automatic test_done();
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   always @(posedge CLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask
   task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK_I);
      WR_I    <= 1'b1;
      ADDR_I  <= a;
      WDATA_I <= d;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask
   // read data sampled in the cycle after the strobe
   task automatic sw_rd(input logic [3:0] a);
      @(posedge CLK_I);
      RD_I   <= 1'b1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 rv = RDATA_O;
   endtask
   // one indirect access, waits for busy to drop
   // command bit 0 write, bit 1 direct basic control access
   task automatic ext(input logic [4:0] dev, input logic [15:0] ofs, input logic [15:0] d, input logic [1:0] w);
      sw_wr(M_DEV_OFS, {11'h000, dev});
      sw_wr(M_REG_OFS, ofs);
      sw_wr(M_DATA_OFS, d);
      sw_wr(M_CMD_OFS, {14'h0000, w});
      rv = 16'h0001;
      for (int i = 0; i < 20 && rv[0] !== 1'b0; i++) sw_rd(M_STAT_OFS);
      chk("status", rv & 16'h0003, 16'h0002);
      if (!w[0]) sw_rd(M_RDATA_OFS);
   endtask
   initial begin
      RST_I       = 1'b1;
      WR_I        = 1'b0;
      RD_I        = 1'b0;
      ADDR_I      = 4'h0;
      WDATA_I     = 16'h0000;
      LED_STRAP_I = 1'b1;
      error_cnt   = 0;
      checks      = 0;
      cyc         = 0;
      repeat (10) @(posedge CLK_I);
      RST_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      #1 chk("led out", {15'h0000, LED_SINGLE_O}, 16'h0001);
      ext(DEV_AN, FLP_HI_OFS, 16'h0000, 1'b0);
      chk("flp hi", rv, FLP_HI_8MS);
      ext(DEV_AN, FLP_LO_OFS, 16'h0000, 1'b0);
      chk("flp lo", rv, FLP_LO_8MS);
      ext(DEV_AN, FLP_HI_OFS, FLP_HI_16MS, 1'b1);
      chk("flp out half", {15'h0000, FLP_16MS_O}, 16'h0000);
      ext(DEV_AN, FLP_LO_OFS, FLP_LO_16MS, 1'b1);
      chk("flp out", {15'h0000, FLP_16MS_O}, 16'h0001);
      ext(DEV_AN, FLP_HI_OFS, 16'h0000, 1'b0);
      chk("flp hi new", rv, FLP_HI_16MS);
      ext(DEV_VENDOR, LED_CTRL_OFS, 16'h0000, 1'b0);
      chk("led reg", rv, 16'h0008);
      ext(DEV_VENDOR, LED_CTRL_OFS, 16'h0000, 1'b1);
      ext(DEV_VENDOR, LED_CTRL_OFS, 16'h0000, 1'b0);
      chk("led reg dual", rv, 16'h0000);
      chk("led out dual", {15'h0000, LED_SINGLE_O}, 16'h0000);
      ext(DEV_VENDOR, LED_CTRL_OFS, 16'h0010, 1'b1);
      ext(DEV_VENDOR, LED_CTRL_OFS, 16'h0000, 1'b0);
      chk("led reg single", rv, 16'h0008);
      ext(DEV_PMA, LINKUP_OFS, 16'h0006, 1'b1);
      ext(DEV_PMA, LINKUP_OFS, 16'h0000, 1'b0);
      chk("linkup locked", rv, 16'h0000);
      chk("linkup out", {15'h0000, LINKUP_SHORT_O}, 16'h0000);
      ext(DEV_AN, 16'h0000, BASIC_FORCED_100, 2'b11);
      ext(DEV_AN, 16'h0000, 16'h0000, 2'b10);
      chk("basic ctrl", rv, BASIC_FORCED_100);
      ext(DEV_PMA, LINKUP_OFS, 16'h0000, 1'b0);
      chk("linkup default", rv, {7'h00, LINKUP_RSVD_RST, LINKUP_DEFAULT, 1'b0});
      ext(DEV_PMA, LINKUP_OFS, {7'h00, LINKUP_RSVD_RST, LINKUP_SHORT, 1'b0}, 1'b1);
      ext(DEV_PMA, LINKUP_OFS, 16'h0000, 1'b0);
      chk("linkup short", rv, {7'h00, LINKUP_RSVD_RST, LINKUP_SHORT, 1'b0});
      chk("linkup out short", {15'h0000, LINKUP_SHORT_O}, 16'h0001);
      ext(DEV_VENDOR, 16'h0001, 16'h0000, 1'b0);
      chk("unmapped ext", rv, 16'h0000);
      sw_rd(M_DIRECT_OFS);
      chk("unmapped sw", rv, 16'h0000);
      test_done();
   end
endmodule
